/* File: hdl/xio_pkg.sv */
// constants shared by the extra i/o block and its level converter
package xio_pkg;

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam logic [15:0] OFS_LINE_GROUP_DIRECTION = 16'hB7FC;
	localparam logic [15:0] OFS_DIGITAL_LINE_DATA = 16'hB806;
	localparam logic [15:0] OFS_ANALOG_LEVEL_0 = 16'hB810;
	localparam logic [15:0] OFS_ANALOG_LEVEL_1 = 16'hB811;
	localparam logic [15:0] OFS_ANALOG_LEVEL_2 = 16'hB812;
	localparam logic [15:0] OFS_ANALOG_LEVEL_3 = 16'hB813;
	localparam logic [15:0] OFS_CONVERTER_UPDATE_STROBE = 16'hB81A;

	// ----------------------------------------------------------------
	// digital lines and direction field
	// ----------------------------------------------------------------
	localparam int unsigned GROUP_W = 8;
	localparam int unsigned GROUP_COUNT = 3;
	localparam int unsigned LINE_COUNT = GROUP_W * GROUP_COUNT;
	localparam logic [2:0] GROUP0_AS_INPUT = 3'h0;
	localparam logic [2:0] GROUP1_AS_INPUT = 3'h0;
	localparam logic [2:0] GROUP2_AS_INPUT = 3'h0;
	localparam logic [2:0] GROUP0_AS_OUTPUT = 3'h1;
	localparam logic [2:0] GROUP1_AS_OUTPUT = 3'h2;
	localparam logic [2:0] GROUP2_AS_OUTPUT = 3'h4;
	localparam logic [2:0] GROUPS_BRACKET_VARIANT = 3'h7;
	localparam logic [2:0] GROUPS_INTERNAL_VARIANT = 3'h3;
	localparam logic [2:0] DIRECTION_RESET = GROUP0_AS_INPUT | GROUP1_AS_INPUT | GROUP2_AS_INPUT;
	localparam logic [23:0] LINE_DATA_RESET = 24'h000000;

	// ----------------------------------------------------------------
	// analog outputs
	// ----------------------------------------------------------------
	localparam int unsigned ANALOG_COUNT = 4;
	localparam int unsigned DAC_W = 12;
	localparam logic [31:0] ANALOG_LEVEL_RESET = 32'h00000000;
	localparam logic [31:0] UPDATE_COMMAND = 32'h00000001;
	localparam logic [11:0] DAC_MID_CODE = 12'h800;
	localparam logic [13:0] MV_PER_STEP = 14'h0005;
	localparam logic [13:0] MV_ROUND_BIAS = 14'h0002;
	localparam logic [31:0] MV_LIMIT = 32'h00002710;

endpackage

/* File: hdl/xio_mv_to_code.sv */
// converts a signed millivolt level into an offset-binary converter code
`timescale 1ns/1ps
module xio_mv_to_code (
	// programmed level
	input wire logic [31:0] level_mv_in,
	// converter code
	output logic [11:0] code_out
);

	logic neg;
	logic [31:0] mag;
	logic [13:0] mag_clamped;
	logic [13:0] steps;

	// ----------------------------------------------------------------
	// rounding and clamping
	// ----------------------------------------------------------------
	// the minimum integer negates to itself; read as unsigned it still clamps
	always_comb begin
		neg = level_mv_in[31];
		mag = neg ? (~level_mv_in + 32'h00000001) : level_mv_in;
		if (mag > xio_pkg::MV_LIMIT) begin
			mag_clamped = xio_pkg::MV_LIMIT[13:0];
		end else begin
			mag_clamped = mag[13:0];
		end
		// nearest step, ties away from zero
		steps = (mag_clamped + xio_pkg::MV_ROUND_BIAS) / xio_pkg::MV_PER_STEP;
		if (neg) begin
			code_out = xio_pkg::DAC_MID_CODE - steps[11:0];
		end else begin
			code_out = xio_pkg::DAC_MID_CODE + steps[11:0];
		end
	end

endmodule

/* File: hdl/xio_extra_io.sv */
// extra i/o block: software digital lines and four updated analog outputs
`timescale 1ns/1ps
//
// Contract
// - bracket variant has 24 lines, direction set per group of eight.
// - internal connector variant has 16 lines in two eight-line groups.
// - direction bit set means output: 1 lines 7..0, 2 lines 15..8, 4 lines 23..16.
// - direction bit clear makes that group an undriven input.
// - one 32-bit data register, bit n maps to line n.
// - data reads return sampled pin levels, outputs included.
// - data writes change only output groups; input bytes are discarded.
// - bits 31..24 of written data are ignored.
// - lines change only by register access, independent of generation.
// - four analog outputs, each with a signed millivolt level register.
// - each output uses a 12-bit converter, 5 mV per step.
// - levels reach outputs only when 1 is written to update; all at once.
// - level reads return the stored programmed value.
module xio_extra_io #(
	parameter bit BRACKET_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register access
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_ack_out,
	output logic reg_err_out,
	// digital lines
	input wire logic [23:0] line_in,
	output logic [23:0] line_out,
	output logic [23:0] line_oe_n_out,
	// analog converters
	output logic [11:0] dac0_code_out,
	output logic [11:0] dac1_code_out,
	output logic [11:0] dac2_code_out,
	output logic [11:0] dac3_code_out,
	output logic dac_load_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam logic [2:0] GROUPS_PRESENT = BRACKET_VARIANT ?
		xio_pkg::GROUPS_BRACKET_VARIANT : xio_pkg::GROUPS_INTERNAL_VARIANT;

	logic [2:0] direction_reg;
	logic [23:0] line_out_reg;
	logic [23:0] line_oe_n_reg;
	logic [23:0] sync1_reg;
	logic [23:0] sync2_reg;
	logic [23:0] sync3_reg;
	logic [23:0] level_reg;
	logic [23:0] present_mask;
	logic [31:0] analog_reg [4];
	logic [11:0] dac_code_reg [4];
	logic [11:0] dac_code_next [4];
	logic dac_load_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic err_reg;
	logic hit_direction;
	logic hit_data;
	logic hit_update;
	logic [3:0] hit_analog;
	logic hit_any;
	logic update_go;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	always_comb begin
		hit_direction = (reg_addr_in == xio_pkg::OFS_LINE_GROUP_DIRECTION);
		hit_data = (reg_addr_in == xio_pkg::OFS_DIGITAL_LINE_DATA);
		hit_update = (reg_addr_in == xio_pkg::OFS_CONVERTER_UPDATE_STROBE);
		hit_analog[0] = (reg_addr_in == xio_pkg::OFS_ANALOG_LEVEL_0);
		hit_analog[1] = (reg_addr_in == xio_pkg::OFS_ANALOG_LEVEL_1);
		hit_analog[2] = (reg_addr_in == xio_pkg::OFS_ANALOG_LEVEL_2);
		hit_analog[3] = (reg_addr_in == xio_pkg::OFS_ANALOG_LEVEL_3);
		hit_any = hit_direction | hit_data | hit_update | (|hit_analog);
	end

	// only an exact 1 fires the update; anything else is dropped silently
	assign update_go = reg_wr_in & hit_update & (reg_wdata_in == xio_pkg::UPDATE_COMMAND);

	// ----------------------------------------------------------------
	// group direction
	// ----------------------------------------------------------------
	// a missing group can never be turned to output, so its pins stay released
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			direction_reg <= xio_pkg::DIRECTION_RESET;
		end else if (reg_wr_in && hit_direction) begin
			direction_reg <= reg_wdata_in[2:0] & GROUPS_PRESENT;
		end
	end

	// ----------------------------------------------------------------
	// per group drive, enables and input sampling
	// ----------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < 3; g++) begin
			present_mask[g*8 +: 8] = {8{GROUPS_PRESENT[g]}};
		end
	end

	// output latch: a group takes write data only while it drives
	// one process per vector so every bit has a single driver
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			line_out_reg <= xio_pkg::LINE_DATA_RESET;
		end else if (reg_wr_in && hit_data) begin
			for (int g = 0; g < 3; g++) begin
				if (direction_reg[g]) begin
					// bits 31..24 have no line behind them and are never stored
					line_out_reg[g*8 +: 8] <= reg_wdata_in[g*8 +: 8];
				end
			end
		end
	end

	// enable follows the direction write in the same cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			line_oe_n_reg <= 24'hFFFFFF;
		end else if (reg_wr_in && hit_direction) begin
			for (int g = 0; g < 3; g++) begin
				line_oe_n_reg[g*8 +: 8] <= {8{~(reg_wdata_in[g] & GROUPS_PRESENT[g])}};
			end
		end
	end

	// three stages; a level is accepted once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_reg <= 24'h000000;
			sync2_reg <= 24'h000000;
			sync3_reg <= 24'h000000;
		end else begin
			sync1_reg <= line_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			level_reg <= 24'h000000;
		end else begin
			for (int i = 0; i < 24; i++) begin
				if (sync2_reg[i] == sync3_reg[i]) begin
					level_reg[i] <= sync3_reg[i];
				end
			end
		end
	end

	assign line_out = line_out_reg;
	assign line_oe_n_out = line_oe_n_reg;

	// ----------------------------------------------------------------
	// analog level shadows
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int a = 0; a < 4; a++) begin
				analog_reg[a] <= xio_pkg::ANALOG_LEVEL_RESET;
			end
		end else begin
			for (int a = 0; a < 4; a++) begin
				if (reg_wr_in && hit_analog[a]) begin
					analog_reg[a] <= reg_wdata_in;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// converters
	// ----------------------------------------------------------------
	// conversion is combinational off the shadows; only the update loads it
	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : gen_dac
			xio_mv_to_code u_conv (
				.level_mv_in(analog_reg[c]),
				.code_out(dac_code_next[c])
			);
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int a = 0; a < 4; a++) begin
				dac_code_reg[a] <= xio_pkg::DAC_MID_CODE;
			end
		end else if (update_go) begin
			// all four load on one edge so the outputs move together
			for (int a = 0; a < 4; a++) begin
				dac_code_reg[a] <= dac_code_next[a];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dac_load_reg <= 1'b0;
		end else begin
			dac_load_reg <= update_go;
		end
	end

	assign dac0_code_out = dac_code_reg[0];
	assign dac1_code_out = dac_code_reg[1];
	assign dac2_code_out = dac_code_reg[2];
	assign dac3_code_out = dac_code_reg[3];
	assign dac_load_out = dac_load_reg;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// update strobe is write only and reads as zero
	always_comb begin
		rdata_next = 32'h00000000;
		if (hit_direction) begin
			rdata_next = {29'h00000000, direction_reg};
		end else if (hit_data) begin
			rdata_next = {8'h00, level_reg & present_mask};
		end else begin
			for (int a = 0; a < 4; a++) begin
				if (hit_analog[a]) begin
					rdata_next = analog_reg[a];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_reg <= 32'h00000000;
		end else if (reg_rd_in) begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= reg_wr_in | reg_rd_in;
		end
	end

	// unmapped offsets still answer, so software never waits on a missing ack
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			err_reg <= 1'b0;
		end else begin
			err_reg <= (reg_wr_in | reg_rd_in) & ~hit_any;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_ack_out = ack_reg;
	assign reg_err_out = err_reg;

endmodule

/* File: verif/xio_extra_io_props.sv */
// port checker for the extra i/o block
`timescale 1ns/1ps
module xio_extra_io_props (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register access
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic reg_ack_out,
	// lines and converters
	input wire logic [23:0] line_out,
	input wire logic [23:0] line_oe_n_out,
	input wire logic [11:0] dac0_code_out,
	input wire logic dac_load_out
);
	logic upd;
	logic dir_wr;
	assign upd = reg_wr_in && reg_addr_in == xio_pkg::OFS_CONVERTER_UPDATE_STROBE
		&& reg_wdata_in == xio_pkg::UPDATE_COMMAND;
	assign dir_wr = reg_wr_in && reg_addr_in == xio_pkg::OFS_LINE_GROUP_DIRECTION;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	req_ack_a: assert property ((reg_wr_in || reg_rd_in) |=> reg_ack_out) else $error("ack missing");
	ack_cause_a: assert property (reg_ack_out |-> $past(reg_wr_in || reg_rd_in)) else $error("stray ack");
	dir_out_a: assert property (dir_wr |=> line_oe_n_out == ~{{8{$past(reg_wdata_in[2])}},
		{8{$past(reg_wdata_in[1])}}, {8{$past(reg_wdata_in[0])}}}) else $error("bad direction");
	data_wr_a: assert property (reg_wr_in && reg_addr_in == xio_pkg::OFS_DIGITAL_LINE_DATA |=>
		((line_out ^ $past(reg_wdata_in[23:0])) & ~line_oe_n_out) == 24'h000000) else $error("bad drive");
	hi_byte_a: assert property (reg_rd_in && reg_addr_in == xio_pkg::OFS_DIGITAL_LINE_DATA |=>
		reg_rdata_out[31:24] == 8'h00) else $error("top byte set");
	line_hold_a: assert property (!reg_wr_in |=> $stable(line_out) && $stable(line_oe_n_out))
		else $error("line moved");
	dac_hold_a: assert property (!upd |=> !dac_load_out && $stable(dac0_code_out))
		else $error("converter moved");
	dac_load_a: assert property (upd |=> dac_load_out) else $error("no load");
endmodule
bind xio_extra_io xio_extra_io_props chk_u (.clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
	.reg_wdata_in, .reg_rdata_out, .reg_ack_out, .line_out, .line_oe_n_out, .dac0_code_out, .dac_load_out);

/* File: verif/xio_equipment.sv */
// far-side equipment on the digital lines
`timescale 1ns/1ps
module xio_equipment (
	// block side
	input wire logic [23:0] drive_in,
	input wire logic [23:0] drive_oe_n_in,
	// equipment pattern
	input wire logic [23:0] pattern_in,
	// resolved pins
	output logic [23:0] pin_out
);
	// a released line shows the equipment level, never the block's last value
	assign pin_out = (drive_in & ~drive_oe_n_in) | (pattern_in & drive_oe_n_in);
endmodule

/* File: verif/tb_xio_extra_io.sv */
// testbench for the extra i/o block
`timescale 1ns/1ps
module tb_xio_extra_io;
	logic clk_in, rst_in, reg_wr_in, reg_rd_in, reg_ack_out, reg_err_out, dac_load_out;
	logic [15:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, rd_val;
	logic [23:0] line_in, line_out, line_oe_n_out, pattern;
	logic [11:0] dac0_code_out, dac1_code_out, dac2_code_out, dac3_code_out;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	xio_extra_io dut_u (.clk_in, .rst_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
		.reg_rdata_out, .reg_ack_out, .reg_err_out, .line_in, .line_out, .line_oe_n_out,
		.dac0_code_out, .dac1_code_out, .dac2_code_out, .dac3_code_out, .dac_load_out);
	xio_equipment equip_u (.drive_in(line_out), .drive_oe_n_in(line_oe_n_out), .pattern_in(pattern),
		.pin_out(line_in));
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [47:0] got, input logic [47:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// one request cycle; answer taken at the following falling edge
	task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data);
		@(negedge clk_in);
		reg_wr_in = wr;
		reg_rd_in = ~wr;
		reg_addr_in = addr;
		reg_wdata_in = data;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		rd_val = reg_rdata_out;
		check({47'h0, reg_ack_out}, 48'h1, "ack");
	endtask
	task automatic t_reset();
		check({24'h0, line_oe_n_out}, 48'hFFFFFF, "oe after reset");
		check({dac0_code_out, dac1_code_out, dac2_code_out, dac3_code_out}, 48'h800800800800, "codes");
	endtask
	task automatic t_dir();
		access(1'b1, xio_pkg::OFS_LINE_GROUP_DIRECTION, 32'h00000005);
		check({24'h0, line_oe_n_out}, 48'h00FF00, "dir 5");
		access(1'b0, xio_pkg::OFS_LINE_GROUP_DIRECTION, 32'h0);
		check({16'h0, rd_val}, 48'h5, "dir read");
	endtask
	task automatic t_data();
		pattern = 24'h3CA577;
		access(1'b1, xio_pkg::OFS_LINE_GROUP_DIRECTION, 32'h00000001);
		access(1'b1, xio_pkg::OFS_DIGITAL_LINE_DATA, 32'hFF3C115A);
		check({24'h0, line_out & ~line_oe_n_out}, 48'h5A, "drive");
		repeat (4) @(negedge clk_in);
		access(1'b0, xio_pkg::OFS_DIGITAL_LINE_DATA, 32'h0);
		check({16'h0, rd_val}, 48'h003CA55A, "pins");
		// the byte sent while group 1 was input must not appear now
		access(1'b1, xio_pkg::OFS_LINE_GROUP_DIRECTION, 32'h00000003);
		repeat (4) @(negedge clk_in);
		access(1'b0, xio_pkg::OFS_DIGITAL_LINE_DATA, 32'h0);
		check({16'h0, rd_val}, 48'h003C005A, "discard");
	endtask
	task automatic levels(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [31:0] d);
		access(1'b1, xio_pkg::OFS_ANALOG_LEVEL_0, a);
		access(1'b1, xio_pkg::OFS_ANALOG_LEVEL_1, b);
		access(1'b1, xio_pkg::OFS_ANALOG_LEVEL_2, c);
		access(1'b1, xio_pkg::OFS_ANALOG_LEVEL_3, d);
	endtask
	task automatic t_analog();
		levels(32'hFFFFF830, 32'h0, 32'h00000DAC, 32'h00002710);
		check({36'h0, dac0_code_out}, 48'h800, "early");
		access(1'b0, xio_pkg::OFS_ANALOG_LEVEL_0, 32'h0);
		check({16'h0, rd_val}, 48'hFFFFF830, "level read");
		access(1'b1, xio_pkg::OFS_CONVERTER_UPDATE_STROBE, 32'h00000002);
		check({dac0_code_out, dac1_code_out, dac2_code_out, dac3_code_out}, 48'h800800800800, "upd 2");
		access(1'b1, xio_pkg::OFS_CONVERTER_UPDATE_STROBE, 32'h00000001);
		check({47'h0, dac_load_out}, 48'h1, "load");
		check({dac0_code_out, dac1_code_out, dac2_code_out, dac3_code_out}, 48'h670800ABCFD0, "upd");
		levels(32'h0000000C, 32'h00004E20, 32'hFFFFFFF4, 32'hFFFFD8F0);
		access(1'b1, xio_pkg::OFS_CONVERTER_UPDATE_STROBE, 32'h00000001);
		check({dac0_code_out, dac1_code_out, dac2_code_out, dac3_code_out}, 48'h802FD07FE030, "round");
	endtask
	// write-only strobe reads zero; an unmapped offset answers with an error
	task automatic t_unmapped();
		access(1'b0, xio_pkg::OFS_CONVERTER_UPDATE_STROBE, 32'h0);
		check({47'h0, reg_err_out}, 48'h0, "update err");
		check({16'h0, rd_val}, 48'h0, "update read");
		access(1'b0, xio_pkg::OFS_LINE_GROUP_DIRECTION, 32'h0);
		check({16'h0, rd_val}, 48'h3, "dir reread");
		access(1'b0, 16'hB800, 32'h0);
		check({47'h0, reg_err_out}, 48'h1, "unmapped err");
		check({16'h0, rd_val}, 48'h0, "unmapped read");
	endtask
	initial begin
		rst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 16'h0000;
		reg_wdata_in = 32'h0;
		pattern = 24'h000000;
		repeat (5) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		t_reset();
		t_dir();
		t_data();
		t_analog();
		t_unmapped();
		test_done();
	end
endmodule
